// File: rtl/sdrc_pkg.sv
// constants, types and the register map for the reclocker control block
package sdrc_pkg;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int ACQ_TIME_MS = 15;
  localparam int LOSS_TIME_MS = 1;
  localparam int FLAG_DELAY_NS = 37;
  // two sync flops, the edge detector and a rate class that settles together with
  // the first transition all eat into the acquire and loss budgets
  localparam int SYNC_CYCLES = 4;
  // longest times round down; the flag delay is held to at least one cycle
  localparam int ACQ_CYCLES = ACQ_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int LOSS_CYCLES = LOSS_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int FLAG_DELAY_CYCLES =
    (FLAG_DELAY_NS / CLK_PERIOD_NS) < 1 ? 1 : FLAG_DELAY_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 18;
  // ==========================================================
  // register map
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_SPEED_LSB = 2;
  localparam int CTRL_CLKMODE_BIT = 4;
  localparam int CTRL_MUTE_N_BIT = 5;
  localparam int CTRL_BYPASS_BIT = 6;
  localparam int STAT_LOCK_BIT = 0;
  localparam int STAT_LOWSPD_BIT = 1;
  localparam int STAT_BYPACT_BIT = 2;
  localparam int STAT_TEST_BIT = 3;
  localparam int STAT_RATE_LSB = 4;
  // reset values mirror the pin pull devices
  localparam logic [1:0] SEL_RESET = 2'h0;
  localparam logic [1:0] SPEED_RESET = 2'h0;
  localparam logic CLKMODE_RESET = 1'b0;
  localparam logic MUTE_N_RESET = 1'b1;
  localparam logic BYPASS_RESET = 1'b0;
  // ==========================================================
  // encodings
  typedef enum logic [1:0] {
    SDRC_SPD_AUTO = 2'b00,
    SDRC_SPD_SD = 2'b01,
    SDRC_SPD_HD = 2'b10,
    SDRC_SPD_TEST = 2'b11
  } sdrc_speed_t;
  // rate class reported by the analog detector for the selected lane
  typedef enum logic [1:0] {
    SDRC_RC_NONE = 2'b00,
    SDRC_RC_SD = 2'b01,
    SDRC_RC_HD = 2'b10,
    SDRC_RC_UNSUP = 2'b11
  } sdrc_rate_t;
endpackage

// File: rtl/sdrc_top.sv
// reclocker control: lock timing, input and mode select, muting, apb registers
`timescale 1ns/1ps
module sdrc_top #(
  parameter int ACQ_CYC = sdrc_pkg::ACQ_CYCLES,
  parameter int LOSS_CYC = sdrc_pkg::LOSS_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] serial_in_lanes,
  input wire logic [1:0] lane_rate_class,
  output logic primary_serial_out_p,
  output logic primary_serial_out_n,
  output logic second_serial_out_p,
  output logic second_serial_out_n,
  output logic lock_detect,
  output logic low_speed_flag,
  output logic bypass_active
);
  import sdrc_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic [3:0] lane_s1;
    logic [3:0] lane_s2;
    logic lane_q;
    logic [1:0] rc_s1;
    logic [1:0] rc_s2;
    logic [1:0] rc_q;
    logic [1:0] sel;
    logic [1:0] speed;
    logic clk_mode;
    logic mute_n;
    logic force_bp;
    logic acq_on;
    logic [CNT_W-1:0] acq_cnt;
    logic [CNT_W-1:0] idle_cnt;
    logic lock;
    logic low_speed;
    logic bp_act;
    logic clk_tgl;
    logic p_p;
    logic p_n;
    logic s_p;
    logic s_n;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } sdrc_state_t;

  // counters end early so lock and loss land inside their windows as seen at the pins
  localparam logic [CNT_W-1:0] ACQ_LAST = CNT_W'(ACQ_CYC - SYNC_CYCLES);
  localparam logic [CNT_W-1:0] LOSS_LAST = CNT_W'(LOSS_CYC - SYNC_CYCLES);

  sdrc_state_t state_reg;
  sdrc_state_t state_next;
  logic cur_bit;
  logic edge_seen;
  logic rate_ok;
  logic rate_changed;
  logic dead;
  logic drop;
  logic unmapped;
  logic ctrl_wr;

  // ==========================================================
  // next state
  always_comb
  begin
    state_next = state_reg;
    // first sync stage feeds only the second
    state_next.lane_s1 = serial_in_lanes;
    state_next.lane_s2 = state_reg.lane_s1;
    state_next.rc_s1 = lane_rate_class;
    state_next.rc_s2 = state_reg.rc_s1;
    state_next.rc_q = state_reg.rc_s2;

    // lane routing by input choice code
    cur_bit = state_reg.lane_s2[state_reg.sel];
    edge_seen = cur_bit != state_reg.lane_q;
    state_next.lane_q = cur_bit;
    rate_changed = state_reg.rc_s2 != state_reg.rc_q;

    // acceptable rate per speed code; harmonics and odd rates are unsupported
    case (state_reg.speed)
      SDRC_SPD_AUTO: rate_ok = state_reg.rc_s2 == SDRC_RC_SD
        || state_reg.rc_s2 == SDRC_RC_HD;
      SDRC_SPD_SD: rate_ok = state_reg.rc_s2 == SDRC_RC_SD;
      SDRC_SPD_HD: rate_ok = state_reg.rc_s2 == SDRC_RC_HD;
      default: rate_ok = 1'b0;
    endcase

    // activity watchdog: silence for the loss window counts as input change
    if (edge_seen)
      state_next.idle_cnt = '0;
    else if (state_reg.idle_cnt != LOSS_LAST)
      state_next.idle_cnt = state_reg.idle_cnt + 1'b1;
    dead = state_reg.idle_cnt == LOSS_LAST;

    // every reason to be unlocked except a control write that changes lane or speed; unsupported rates never reach lock
    drop = state_reg.force_bp || !rate_ok || rate_changed || dead;

    // acquisition counts from the first transition
    if (drop)
    begin
      state_next.acq_on = 1'b0;
      state_next.acq_cnt = '0;
      state_next.lock = 1'b0;
    end
    else if (!state_reg.acq_on && !state_reg.lock)
    begin
      if (edge_seen)
      begin
        state_next.acq_on = 1'b1;
        state_next.acq_cnt = CNT_W'(1);
      end
    end
    else if (state_reg.acq_on)
    begin
      state_next.acq_cnt = state_reg.acq_cnt + 1'b1;
      if (state_reg.acq_cnt == ACQ_LAST)
      begin
        state_next.acq_on = 1'b0;
        state_next.lock = 1'b1;
      end
    end

    // rate flag follows lock by one clock, low while unlocked
    state_next.low_speed = state_reg.lock && state_reg.rc_q == SDRC_RC_SD;

    // forced, or automatic while unlocked or unsupported
    state_next.bp_act = state_reg.force_bp || !state_reg.lock;

    // stand-in for the recovered clock, centred by the analog loop
    state_next.clk_tgl = !state_reg.clk_tgl;

    // outputs: mute wins over everything, static with legs opposite
    if (!state_reg.mute_n)
    begin
      state_next.p_p = 1'b0;
      state_next.p_n = 1'b1;
      state_next.s_p = 1'b0;
      state_next.s_n = 1'b1;
    end
    else
    begin
      state_next.p_p = cur_bit;
      state_next.p_n = !cur_bit;
      if (!state_reg.clk_mode)
      begin
        state_next.s_p = cur_bit;
        state_next.s_n = !cur_bit;
      end
      else if (state_reg.bp_act)
      begin
        // no valid clock under bypass, so hold it quiet
        state_next.s_p = 1'b0;
        state_next.s_n = 1'b1;
      end
      else
      begin
        state_next.s_p = state_reg.clk_tgl;
        state_next.s_n = !state_reg.clk_tgl;
      end
    end

    // apb: answer one cycle into the access phase
    unmapped = paddr != CTRL_OFFSET && paddr != STATUS_OFFSET;
    ctrl_wr = psel && penable && state_reg.pready && pwrite && !state_reg.pslverr
      && paddr == CTRL_OFFSET;
    if (psel && penable && !state_reg.pready)
    begin
      state_next.pready = 1'b1;
      state_next.pslverr = unmapped || (pwrite && paddr == STATUS_OFFSET);
      state_next.prdata = '0;
      if (!pwrite && paddr == CTRL_OFFSET)
      begin
        state_next.prdata[CTRL_SEL_LSB +: 2] = state_reg.sel;
        state_next.prdata[CTRL_SPEED_LSB +: 2] = state_reg.speed;
        state_next.prdata[CTRL_CLKMODE_BIT] = state_reg.clk_mode;
        state_next.prdata[CTRL_MUTE_N_BIT] = state_reg.mute_n;
        state_next.prdata[CTRL_BYPASS_BIT] = state_reg.force_bp;
      end
      else if (!pwrite && paddr == STATUS_OFFSET)
      begin
        state_next.prdata[STAT_LOCK_BIT] = state_reg.lock;
        state_next.prdata[STAT_LOWSPD_BIT] = state_reg.low_speed;
        state_next.prdata[STAT_BYPACT_BIT] = state_reg.bp_act;
        state_next.prdata[STAT_TEST_BIT] = state_reg.speed == SDRC_SPD_TEST;
        state_next.prdata[STAT_RATE_LSB +: 2] = state_reg.rc_q;
      end
    end
    else
    begin
      state_next.pready = 1'b0;
      state_next.pslverr = 1'b0;
    end

    // control write lands on the completing edge; a new lane or mode relocks
    if (ctrl_wr)
    begin
      state_next.sel = pwdata[CTRL_SEL_LSB +: 2];
      state_next.speed = pwdata[CTRL_SPEED_LSB +: 2];
      state_next.clk_mode = pwdata[CTRL_CLKMODE_BIT];
      state_next.mute_n = pwdata[CTRL_MUTE_N_BIT];
      state_next.force_bp = pwdata[CTRL_BYPASS_BIT];
      if (pwdata[CTRL_SEL_LSB +: 2] != state_reg.sel
        || pwdata[CTRL_SPEED_LSB +: 2] != state_reg.speed)
      begin
        state_next.lock = 1'b0;
        state_next.acq_on = 1'b0;
        state_next.acq_cnt = '0;
      end
    end
  end

  // ==========================================================
  // registers; reset values match the pin pull devices
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= '0;
      state_reg.sel <= SEL_RESET;
      state_reg.speed <= SPEED_RESET;
      state_reg.clk_mode <= CLKMODE_RESET;
      state_reg.mute_n <= MUTE_N_RESET;
      state_reg.force_bp <= BYPASS_RESET;
      state_reg.bp_act <= 1'b1;
      state_reg.p_n <= 1'b1;
      state_reg.s_n <= 1'b1;
    end
    else
      state_reg <= state_next;
  end

  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;
  assign primary_serial_out_p = state_reg.p_p;
  assign primary_serial_out_n = state_reg.p_n;
  assign second_serial_out_p = state_reg.s_p;
  assign second_serial_out_n = state_reg.s_n;
  assign lock_detect = state_reg.lock;
  assign low_speed_flag = state_reg.low_speed;
  assign bypass_active = state_reg.bp_act;

  // ==========================================================
  // checks
  property p_bypass_unlock;
    @(posedge pclk) disable iff (!presetn)
    state_reg.force_bp |=> !lock_detect;
  endproperty
  a_bypass_unlock: assert property (p_bypass_unlock)
    else $error("lock high under forced bypass");

  property p_flag_low;
    @(posedge pclk) disable iff (!presetn)
    !lock_detect |=> !low_speed_flag;
  endproperty
  a_flag_low: assert property (p_flag_low)
    else $error("rate flag high while unlocked");

  property p_flag_delay;
    @(posedge pclk) disable iff (!presetn)
    $rose(lock_detect) && state_reg.rc_q == SDRC_RC_SD ##1 lock_detect |-> low_speed_flag;
  endproperty
  a_flag_delay: assert property (p_flag_delay)
    else $error("rate flag late after lock");

  property p_mute;
    @(posedge pclk) disable iff (!presetn)
    !state_reg.mute_n |=> !primary_serial_out_p && primary_serial_out_n
      && !second_serial_out_p && second_serial_out_n;
  endproperty
  a_mute: assert property (p_mute)
    else $error("output not muted");

  property p_mute_static;
    @(posedge pclk) disable iff (!presetn)
    !state_reg.mute_n [*3] |-> $stable(primary_serial_out_p) && $stable(second_serial_out_p);
  endproperty
  a_mute_static: assert property (p_mute_static)
    else $error("muted output toggles");

  property p_clk_bypass;
    @(posedge pclk) disable iff (!presetn)
    state_reg.mute_n && state_reg.clk_mode && bypass_active
      |=> !second_serial_out_p && second_serial_out_n;
  endproperty
  a_clk_bypass: assert property (p_clk_bypass)
    else $error("clock output live in bypass");

  property p_unsup;
    @(posedge pclk) disable iff (!presetn)
    state_reg.rc_s2 == SDRC_RC_UNSUP |=> !lock_detect ##1 bypass_active;
  endproperty
  a_unsup: assert property (p_unsup)
    else $error("locked or not bypassed at unsupported rate");

  property p_mode_rate;
    @(posedge pclk) disable iff (!presetn)
    lock_detect && state_reg.speed == SDRC_SPD_SD |-> state_reg.rc_q == SDRC_RC_SD;
  endproperty
  a_mode_rate: assert property (p_mode_rate)
    else $error("locked at rate outside fixed mode");

  property p_sel_drop;
    @(posedge pclk) disable iff (!presetn)
    $changed(state_reg.sel) |-> !lock_detect;
  endproperty
  a_sel_drop: assert property (p_sel_drop)
    else $error("lock held across input change");

  property p_data_copy;
    @(posedge pclk) disable iff (!presetn)
    state_reg.mute_n && !state_reg.clk_mode
      |=> second_serial_out_p == primary_serial_out_p;
  endproperty
  a_data_copy: assert property (p_data_copy)
    else $error("second output not a data copy");

  property p_acq_start;
    @(posedge pclk) disable iff (!presetn)
    $rose(lock_detect) |-> $past(state_reg.acq_on);
  endproperty
  a_acq_start: assert property (p_acq_start)
    else $error("lock rose without a running acquisition");

  property p_lock_rate;
    @(posedge pclk) disable iff (!presetn)
    lock_detect |-> state_reg.rc_q == SDRC_RC_SD || state_reg.rc_q == SDRC_RC_HD;
  endproperty
  a_lock_rate: assert property (p_lock_rate)
    else $error("locked at an unsupported rate");

  property p_test_unlock;
    @(posedge pclk) disable iff (!presetn)
    state_reg.speed == SDRC_SPD_TEST |=> !lock_detect;
  endproperty
  a_test_unlock: assert property (p_test_unlock)
    else $error("locked in test mode");

  property p_retime;
    @(posedge pclk) disable iff (!presetn)
    lock_detect && !state_reg.force_bp |=> !bypass_active;
  endproperty
  a_retime: assert property (p_retime)
    else $error("bypassed while locked");

  property p_flag_hd;
    @(posedge pclk) disable iff (!presetn)
    lock_detect && state_reg.rc_q == SDRC_RC_HD |=> !low_speed_flag;
  endproperty
  a_flag_hd: assert property (p_flag_hd)
    else $error("rate flag high at the fast rates");

  property p_clk_toggle;
    @(posedge pclk) disable iff (!presetn)
    (state_reg.mute_n && state_reg.clk_mode && !bypass_active) [*2]
      |=> second_serial_out_p != $past(second_serial_out_p);
  endproperty
  a_clk_toggle: assert property (p_clk_toggle)
    else $error("clock output not toggling");

  property p_silence;
    @(posedge pclk) disable iff (!presetn)
    state_reg.idle_cnt == LOSS_LAST |=> !lock_detect;
  endproperty
  a_silence: assert property (p_silence)
    else $error("lock held through a silent input");
endmodule

// File: testbench/sdrc_eq_model.sv
// upstream equalizer model: lane levels and detected rate class
`timescale 1ns/1ps
module sdrc_eq_model (
  input wire logic pclk,
  input wire logic [3:0] data_pattern,
  input wire logic [3:0] toggle_en,
  input wire logic [1:0] rate_in,
  output logic [3:0] serial_in_lanes,
  output logic [1:0] lane_rate_class
);
  logic phase_reg = 1'b0;
  // ==========================================================
  // lane data
  // a live lane flips every pclk, far inside the loss window, so lock never
  // drops by silence; an idle lane rests at its pattern level
  always @(posedge pclk)
  begin
    phase_reg <= ~phase_reg;
  end
  assign serial_in_lanes = data_pattern ^ (toggle_en & {4{phase_reg}});
  // detector verdict for the chosen lane, harmonics reported as unsupported
  assign lane_rate_class = rate_in;
endmodule

// File: testbench/tb_sdrc_top.sv
// self-checking bench for the reclocker control block
`timescale 1ns/1ps
module tb_sdrc_top;
  import sdrc_pkg::*;
  localparam int ACQ = 20;
  localparam int LOSS = 8;
  // speed code, rate class, lock expected
  localparam logic [4:0] TBL [8] = '{5'h03, 5'h05, 5'h0B, 5'h0C, 5'h15, 5'h12, 5'h06, 5'h1A};
  typedef struct packed {logic wr; logic err; logic [31:0] data;} sdrc_note_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hold;
  logic prim_p, prim_n, sec_p, sec_n, lock_detect, low_speed_flag, bypass_active;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] lanes, pattern, toggles;
  logic [1:0] rate_class, rate;
  sdrc_note_t notes[$];
  sdrc_note_t nt;
  int num_errors, cmp_count, seed, n;

  sdrc_top #(.ACQ_CYC(ACQ), .LOSS_CYC(LOSS)) sdrc_top_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_in_lanes(lanes),
    .lane_rate_class(rate_class), .primary_serial_out_p(prim_p),
    .primary_serial_out_n(prim_n), .second_serial_out_p(sec_p), .second_serial_out_n(sec_n),
    .lock_detect(lock_detect), .low_speed_flag(low_speed_flag), .bypass_active(bypass_active));
  sdrc_eq_model sdrc_eq_model_inst (.pclk(pclk), .data_pattern(pattern), .toggle_en(toggles),
    .rate_in(rate), .serial_in_lanes(lanes), .lane_rate_class(rate_class));

  // ==========================================================
  // clock, watchdog and comparisons
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // the whole run needs about 500 cycles; a hang is cut far beyond that
  initial
  begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    close_out();
  end
  task automatic chk_bit(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // bus answers are matched in order against the notes queued by the driver
  always @(posedge pclk)
  begin
    if (pready === 1'b1)
    begin
      nt = notes.pop_front();
      chk_bit("pslverr", nt.err, pslverr);
      if (!nt.wr && !nt.err)
        chk_word("prdata", nt.data, prdata);
    end
  end

  // ==========================================================
  // drivers
  // one apb transfer; an idle edge follows so psel is never set twice at one time
  // the wait for pready has no limit of its own, only the watchdog ends a hang
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      input logic [31:0] exp, input logic err);
    notes.push_back('{wr, err, exp});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr_ctrl(input logic [6:0] v);
    apb(1'b1, CTRL_OFFSET, {25'h0, v}, 32'h0, 1'b0);
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge pclk);
  endtask
  task automatic wait_lock(input logic lvl, input int lim, output int cnt);
    cnt = 0;
    while (lock_detect !== lvl && cnt < lim)
    begin
      @(posedge pclk);
      cnt++;
    end
  endtask
  task automatic chk_muted();
    chk_bit("primary_p", 1'b0, prim_p);
    chk_bit("primary_n", 1'b1, prim_n);
    chk_bit("second_p", 1'b0, sec_p);
    chk_bit("second_n", 1'b1, sec_n);
  endtask
  function automatic logic [31:0] stat(input logic [1:0] rc, input logic tst, input logic lk,
      input logic lo);
    return {26'h0, rc, tst, ~lk, lo, lk};
  endfunction

  // ==========================================================
  // scenarios
  initial
  begin
    seed = 27;
    num_errors = 0;
    cmp_count = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pattern = 4'h0;
    toggles = 4'h0;
    rate = SDRC_RC_NONE;
    tick(10);
    presetn <= 1'b1;
    tick(1);
    // reset values, unmapped read and a refused write to status
    apb(1'b0, CTRL_OFFSET, 32'h0, 32'h20, 1'b0);
    apb(1'b0, STATUS_OFFSET, 32'h0, stat(2'h0, 1'b0, 1'b0, 1'b0), 1'b0);
    apb(1'b0, 8'h08, 32'h0, 32'h0, 1'b1);
    apb(1'b1, STATUS_OFFSET, 32'hFF, 32'h0, 1'b1);
    // every input choice code with random idle lane levels
    for (int s = 0; s < 4; s++)
    begin
      pattern <= 4'($random(seed));
      wr_ctrl(7'h20 | 7'(s));
      tick(6);
      chk_bit("primary_p", pattern[s], prim_p);
      chk_bit("primary_n", ~pattern[s], prim_n);
      chk_bit("second_p", pattern[s], sec_p);
      chk_bit("bypass_active", 1'b1, bypass_active);
    end
    // each speed code against a few rate classes, unsupported only under auto; code 11 is driven on purpose
    foreach (TBL[i])
    begin
      wr_ctrl({3'h2, TBL[i][4:3], 2'h0});
      rate <= TBL[i][2:1];
      toggles <= 4'h1;
      wait_lock(1'b1, ACQ + 12, n);
      if (TBL[i][0])
      begin
        chk_bit("acquire_time", 1'b1, n >= ACQ && n <= ACQ + 2);
        tick(1);
        chk_bit("low_speed_flag", TBL[i][2:1] == 2'h1, low_speed_flag);
        chk_bit("bypass_active", 1'b0, bypass_active);
      end
      else
        chk_bit("lock_detect", 1'b0, lock_detect);
      apb(1'b0, STATUS_OFFSET, 32'h0, stat(TBL[i][2:1], TBL[i][4:3] == 2'h3, TBL[i][0],
        TBL[i][0] && TBL[i][2:1] == 2'h1), 1'b0);
      rate <= SDRC_RC_NONE;
      toggles <= 4'h0;
      wait_lock(1'b0, LOSS + 6, n);
      chk_bit("lock_loss", 1'b1, n <= LOSS);
      tick(1);
      chk_bit("low_speed_flag", 1'b0, low_speed_flag);
    end
    // clock on the second output, then mute, forced bypass, mute over bypass
    wr_ctrl(7'h30);
    rate <= SDRC_RC_SD;
    toggles <= 4'h1;
    wait_lock(1'b1, ACQ + 12, n);
    tick(2);
    hold = sec_p;
    tick(1);
    chk_bit("second_toggle", ~hold, sec_p);
    chk_bit("second_n", ~sec_p, sec_n);
    wr_ctrl(7'h10);
    tick(2);
    chk_muted();
    wr_ctrl(7'h70);
    tick(4);
    chk_bit("lock_detect", 1'b0, lock_detect);
    chk_bit("bypass_active", 1'b1, bypass_active);
    chk_bit("second_p", 1'b0, sec_p);
    chk_bit("second_n", 1'b1, sec_n);
    chk_bit("primary_n", ~prim_p, prim_n);
    wr_ctrl(7'h50);
    tick(2);
    chk_muted();
    // back to defaults, relock, then silence the lane: loss by inactivity
    wr_ctrl(7'h20);
    wait_lock(1'b1, ACQ + 12, n);
    chk_bit("relock", 1'b1, lock_detect);
    toggles <= 4'h0;
    wait_lock(1'b0, LOSS + 6, n);
    chk_bit("silence_loss", 1'b1, n <= LOSS + 1);
    close_out();
  end
endmodule
